// *** cmt_defs.svh ***
// Register offsets, field positions and reset values of the timer channel.
// Assumes byte addressing on a 32-bit Wishbone bus, one register per word.
`ifndef CMT_DEFS_SVH
`define CMT_DEFS_SVH

`define CMT_ADR_W           8
`define CMT_ADR_CTRL        8'h00
`define CMT_ADR_LATCH       8'h04
`define CMT_ADR_COUNT       8'h08
`define CMT_ADR_STATUS      8'h0C
`define CMT_ADR_IRQ_CLEAR   8'h10
`define CMT_ADR_IRQ_ENABLE  8'h14

`define CMT_CTRL_SW_RESET   0
`define CMT_CTRL_DUAL_BYTE  2
`define CMT_CTRL_MODE_LOW   3
`define CMT_CTRL_INIT_INH   4
`define CMT_CTRL_MODE_HIGH  5
`define CMT_CTRL_OUT_EN     7

`define CMT_STAT_EXPIRY     0

`define CMT_CTRL_RESET      8'h00
`define CMT_LATCH_RESET     16'h0000
`define CMT_COUNT_RESET     16'h0000

`define CMT_SYNC_STAGES     2

`endif

// *** cmt_pkg.sv ***
// Types shared by the timer channel: the bundle of timer pins and the
// register state of the channel, apart from its reset and pin synchroniser flops.
package cmt_pkg;

  typedef struct packed {
    logic clk;
    logic gate;
    logic rst_n;
  } cmt_pins_s;

  typedef struct packed {
    logic [7:0]  ctrl;
    logic [15:0] latch;
    logic [15:0] count;
    logic        expiry_flag;
    logic        irq_enable;
    logic        wave;
    logic        clk_prev;
    logic        gate_prev;
    logic        ack;
    logic [31:0] dat;
    logic        pin_out;
    logic        irq;
  } cmt_state_s;

endpackage

// *** cmt_sync.sv ***
// Two-flop synchroniser for a group of asynchronous timer pins.
// Assumes the reset is already synchronous to the clock on release.
`timescale 1ns/1ps

module cmt_sync
  import cmt_pkg::*;
#(
  parameter int WIDTH = 3
)
(
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  // Data
  input  wire logic [WIDTH-1:0] d_in,
  output logic      [WIDTH-1:0] q_out
);

  logic [WIDTH-1:0] meta;

  // Meta stage feeds only the second stage
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      meta  <= '0;
      q_out <= '0;
    end
    else
    begin
      meta  <= d_in;
      q_out <= meta;
    end
  end

endmodule

// *** cmt_timer.sv ***
// One continuous-mode timer channel with a Wishbone register slave.
// Assumes timer clock, gate and external reset pins are asynchronous.
`timescale 1ns/1ps
`include "cmt_defs.svh"

module cmt_timer
  import cmt_pkg::*;
(
  // System clock and reset
  input  wire logic        CLK_SYS_IN,
  input  wire logic        RST_N_IN,
  // Wishbone slave
  input  wire logic        WB_CYC_IN,
  input  wire logic        WB_STB_IN,
  input  wire logic        WB_WE_IN,
  input  wire logic [7:0]  WB_ADR_IN,
  input  wire logic [3:0]  WB_SEL_IN,
  input  wire logic [31:0] WB_DAT_IN,
  output logic      [31:0] WB_DAT_OUT,
  output logic             WB_ACK_OUT,
  // Timer pins
  input  wire logic        TMR_CLK_IN,
  input  wire logic        TMR_GATE_IN,
  input  wire logic        TMR_RST_N_IN,
  output logic             CHANNEL_WAVE_OUT,
  // Interrupt
  output logic             IRQ_OUT
);

  cmt_state_s st;
  cmt_state_s next_st;

  logic       rst_meta;
  logic       rst_n_sync;
  cmt_pins_s  pins_raw;
  cmt_pins_s  pins;

  logic        bus_req;
  logic        bus_wr;
  logic        latch_wr;
  logic        clear_wr;
  logic        timer_rst;
  logic        clk_tick;
  logic        gate_fall;
  logic        continuous;
  logic        init;
  logic        enabled;
  logic        expiry;
  logic [15:0] count;
  logic        wave;

  function automatic logic hit(input logic [7:0] adr,
                               input logic [7:0] off);
    hit = (adr[7:2] == off[7:2]);
  endfunction

  // Reset release through two flops, assertion stays asynchronous
  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      rst_meta   <= 1'b0;
      rst_n_sync <= 1'b0;
    end
    else
    begin
      rst_meta   <= 1'b1;
      rst_n_sync <= rst_meta;
    end
  end

  assign pins_raw.clk   = TMR_CLK_IN;
  assign pins_raw.gate  = TMR_GATE_IN;
  assign pins_raw.rst_n = TMR_RST_N_IN;

  cmt_sync #(
    .WIDTH ($bits(cmt_pins_s))
  ) u_sync (
    .clk_in   (CLK_SYS_IN),
    .rst_n_in (rst_n_sync),
    .d_in     (pins_raw),
    .q_out    (pins)
  );

  always_comb
  begin
    next_st = st;

    // Bus slave: single-cycle ack, dropped the cycle after
    bus_req     = WB_CYC_IN & WB_STB_IN & ~st.ack;
    bus_wr      = bus_req & WB_WE_IN;
    next_st.ack = bus_req;
    next_st.dat = 32'h0000_0000;
    latch_wr    = 1'b0;
    clear_wr    = 1'b0;

    if (bus_req && !WB_WE_IN)
    begin
      if (hit(WB_ADR_IN, `CMT_ADR_CTRL))
        next_st.dat = {24'h00_0000, st.ctrl};
      else if (hit(WB_ADR_IN, `CMT_ADR_LATCH))
        next_st.dat = {16'h0000, st.latch};
      else if (hit(WB_ADR_IN, `CMT_ADR_COUNT))
        next_st.dat = {16'h0000, st.count};
      else if (hit(WB_ADR_IN, `CMT_ADR_STATUS))
        next_st.dat = {31'h0000_0000, st.expiry_flag};
      else if (hit(WB_ADR_IN, `CMT_ADR_IRQ_ENABLE))
        next_st.dat = {31'h0000_0000, st.irq_enable};
      else
        next_st.dat = 32'h0000_0000;
    end

    if (bus_wr)
    begin
      if (hit(WB_ADR_IN, `CMT_ADR_CTRL) && WB_SEL_IN[0])
        next_st.ctrl = WB_DAT_IN[7:0];
      if (hit(WB_ADR_IN, `CMT_ADR_LATCH))
      begin
        latch_wr = |WB_SEL_IN[1:0];
        if (WB_SEL_IN[0])
          next_st.latch[7:0] = WB_DAT_IN[7:0];
        if (WB_SEL_IN[1])
          next_st.latch[15:8] = WB_DAT_IN[15:8];
      end
      if (hit(WB_ADR_IN, `CMT_ADR_IRQ_CLEAR) && WB_SEL_IN[0])
        clear_wr = WB_DAT_IN[`CMT_STAT_EXPIRY];
      if (hit(WB_ADR_IN, `CMT_ADR_IRQ_ENABLE) && WB_SEL_IN[0])
        next_st.irq_enable = WB_DAT_IN[`CMT_STAT_EXPIRY];
    end

    // Edge stage after the synchroniser: action at the third edge
    next_st.clk_prev  = pins.clk;
    next_st.gate_prev = pins.gate;
    clk_tick  = st.clk_prev & ~pins.clk;
    gate_fall = st.gate_prev & ~pins.gate;

    timer_rst  = st.ctrl[`CMT_CTRL_SW_RESET] | ~pins.rst_n;
    continuous = ~st.ctrl[`CMT_CTRL_MODE_LOW]
               & ~st.ctrl[`CMT_CTRL_MODE_HIGH];

    // Other modes are outside this channel; only reset initialises there
    init = timer_rst
         | (continuous & gate_fall)
         | (continuous & latch_wr
            & ~st.ctrl[`CMT_CTRL_INIT_INH]);

    // Reset also keeps the counter loaded from the latches
    count = init ? next_st.latch : st.count;
    wave  = init ? 1'b0 : st.wave;

    // Tick in a gate-fall or latch-write init cycle counts too, so first clock is not lost
    enabled = continuous & ~timer_rst & ~pins.gate;
    expiry  = 1'b0;

    if (enabled && clk_tick)
    begin
      if (!st.ctrl[`CMT_CTRL_DUAL_BYTE])
      begin
        if (count == 16'h0000)
        begin
          expiry = 1'b1;
          count  = next_st.latch;
          wave   = ~wave;
        end
        else
        begin
          count = count - 16'h0001;
        end
      end
      else if (next_st.latch == 16'h0000)
      begin
        wave = ~wave;
      end
      else if (next_st.latch[7:0] == 8'h00)
      begin
        if (count[15:8] == 8'h00)
        begin
          expiry = 1'b1;
          count  = next_st.latch;
          wave   = ~wave;
        end
        else
        begin
          count = {count[15:8] - 8'h01, 8'h00};
        end
      end
      else if (count == 16'h0000)
      begin
        expiry = 1'b1;
        count  = next_st.latch;
        wave   = 1'b0;
      end
      else if (count[7:0] == 8'h00)
      begin
        count = {count[15:8] - 8'h01, next_st.latch[7:0]};
      end
      else
      begin
        if (count[15:8] == 8'h00)
          wave = 1'b1;
        count = {count[15:8], count[7:0] - 8'h01};
      end
    end

    next_st.count = count;
    next_st.wave  = wave;

    // Expiry wins over a same-cycle clear or initialisation
    next_st.expiry_flag = (st.expiry_flag & ~clear_wr & ~init)
                        | expiry;

    // Gated by the new control value so disable acts on the next edge
    next_st.pin_out = wave & next_st.ctrl[`CMT_CTRL_OUT_EN];
    next_st.irq     = next_st.expiry_flag & next_st.irq_enable;
  end

  always_ff @(posedge CLK_SYS_IN or negedge rst_n_sync)
  begin
    if (!rst_n_sync)
    begin
      st             <= '0;
      st.ctrl        <= `CMT_CTRL_RESET;
      st.latch       <= `CMT_LATCH_RESET;
      st.count       <= `CMT_COUNT_RESET;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign WB_DAT_OUT       = st.dat;
  assign WB_ACK_OUT       = st.ack;
  assign CHANNEL_WAVE_OUT = st.pin_out;
  assign IRQ_OUT          = st.irq;

endmodule

// *** cmt_timer_assertions.sv ***
// Port-level checks of the continuous-mode timer channel.
// Assumes binding to cmt_timer; one clock domain.
`timescale 1ns/1ps
module cmt_timer_assertions
(
  // Clock, reset and bus
  input wire logic        CLK_SYS_IN,
  input wire logic        RST_N_IN,
  input wire logic        WB_CYC_IN,
  input wire logic        WB_STB_IN,
  input wire logic        WB_WE_IN,
  input wire logic [7:0]  WB_ADR_IN,
  input wire logic [3:0]  WB_SEL_IN,
  input wire logic [31:0] WB_DAT_IN,
  input wire logic [31:0] WB_DAT_OUT,
  input wire logic        WB_ACK_OUT,
  // Timer pins and interrupt
  input wire logic        TMR_GATE_IN,
  input wire logic        TMR_RST_N_IN,
  input wire logic        CHANNEL_WAVE_OUT,
  input wire logic        IRQ_OUT
);
  logic take;
  logic wr0;
  assign take = WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT;
  // Lane 0 write taken at this edge
  assign wr0 = take && WB_WE_IN && WB_SEL_IN[0];
  default clocking @(posedge CLK_SYS_IN); endclocking
  default disable iff (!RST_N_IN);
  ack_single_pulse_a:
    assert property (WB_ACK_OUT |=> !WB_ACK_OUT) else $error("ack too long");
  ack_next_edge_a:
    assert property (take |=> WB_ACK_OUT) else $error("request unanswered");
  data_idle_zero_a:
    assert property (!WB_ACK_OUT |-> WB_DAT_OUT == '0)
      else $error("read data not zero when idle");
  out_en_low_a:
    assert property (wr0 && WB_ADR_IN == 8'h00 && !WB_DAT_IN[7]
      |=> !CHANNEL_WAVE_OUT) else $error("output high after disable");
  sw_reset_low_a:
    assert property (wr0 && WB_ADR_IN == 8'h00 && WB_DAT_IN[0]
      |-> ##2 !CHANNEL_WAVE_OUT) else $error("output high in reset");
  pin_reset_low_a:
    assert property (!TMR_RST_N_IN [*4] |=> !CHANNEL_WAVE_OUT)
      else $error("output high under pin reset");
  pin_reset_flag_a:
    assert property (!TMR_RST_N_IN [*4] |=> !IRQ_OUT)
      else $error("interrupt under pin reset");
  gate_hold_a:
    assert property ((TMR_GATE_IN && TMR_RST_N_IN && !WB_STB_IN) [*6]
      |-> $stable(CHANNEL_WAVE_OUT)) else $error("output moved, gate high");
  irq_mask_a:
    assert property (wr0 && WB_ADR_IN == 8'h14 && !WB_DAT_IN[0]
      |-> ##2 !IRQ_OUT) else $error("masked interrupt still high");
  cover property (wr0 && WB_ADR_IN == 8'h04);
  cover property ($rose(IRQ_OUT));
  cover property ($fell(CHANNEL_WAVE_OUT));
endmodule

bind cmt_timer cmt_timer_assertions cmt_timer_assertions_inst (.CLK_SYS_IN,
  .RST_N_IN, .WB_CYC_IN, .WB_STB_IN, .WB_WE_IN, .WB_ADR_IN, .WB_SEL_IN,
  .WB_DAT_IN, .WB_DAT_OUT, .WB_ACK_OUT, .TMR_GATE_IN, .TMR_RST_N_IN,
  .CHANNEL_WAVE_OUT, .IRQ_OUT);

// *** cmt_pins_model.sv ***
// Far-side sources of the timer clock, gate and reset pins.
// Assumes the bench steers gate and reset; the clock ticks on its own while run_in is high.
`timescale 1ns/1ps
module cmt_pins_model
  import cmt_pkg::*;
(
  // System clock
  input  wire logic clk_in,
  // Controls
  input  wire logic run_in,
  input  wire logic gate_in,
  input  wire logic rst_n_in,
  // Pins
  output cmt_pins_s pins_out
);
  int ph = 0;
  initial pins_out = 3'b111;
  // Three clocks per level, above the two-clock minimum
  always @(posedge clk_in)
  begin
    ph <= (ph == 2) ? 0 : ph + 1;
    if (run_in && ph == 2)
      pins_out.clk <= ~pins_out.clk;
    pins_out.gate <= gate_in;
    pins_out.rst_n <= rst_n_in;
  end
endmodule

// *** cmt_timer_bench.sv ***
// Self-checking bench of the continuous-mode timer channel.
// Assumes a pin model giving one count tick every six system clocks.
`timescale 1ns/1ps
module cmt_timer_bench
  import cmt_pkg::*;
;
  logic        clk, rst_n, cyc, stb, we, ack, out, irq, gate, trst_n, run, v;
  logic [7:0]  adr;
  logic [31:0] wdat, rdat, r;
  cmt_pins_s   pins;
  int          n_errors, n_tests, cycles, c, n, m, l;
  integer      seed = 32'hf18e_db4e;

  initial
  begin
    clk = 0;
    forever #25 clk = ~clk;
  end

  cmt_timer cmt_timer_inst (.CLK_SYS_IN(clk), .RST_N_IN(rst_n),
    .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr),
    .WB_SEL_IN(4'hf), .WB_DAT_IN(wdat), .WB_DAT_OUT(rdat),
    .WB_ACK_OUT(ack), .TMR_CLK_IN(pins.clk), .TMR_GATE_IN(pins.gate),
    .TMR_RST_N_IN(pins.rst_n), .CHANNEL_WAVE_OUT(out), .IRQ_OUT(irq));
  cmt_pins_model cmt_pins_model_inst (.clk_in(clk), .run_in(run),
    .gate_in(gate), .rst_n_in(trst_n), .pins_out(pins));

  task chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e)
    begin
      n_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    r = rdat;
    cyc <= 0;
    stb <= 0;
  endtask

  // Length in clocks of a whole output level; v gives that level.
  // Two levels skipped first: one partial, one possibly cut by an init.
  task meas;
    repeat (3)
    begin
      v = out;
      c = 0;
      while (out === v && c < 900)
      begin
        @(posedge clk);
        c++;
      end
    end
  endtask

  task print_verdict;
    $display("errors=%0d checks=%0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      n_errors++;
      print_verdict;
    end
  end

  initial
  begin
    {rst_n, cyc, stb, we, adr, wdat, run} = '0;
    {gate, trst_n} = 2'b11;
    {n_errors, n_tests, cycles} = '0;
    repeat (6) @(posedge clk);
    rst_n <= 1;
    repeat (3) @(posedge clk);
    wb(1, 8'h40, 32'h0000_00ff);
    for (int i = 0; i <= 64; i += 4)
    begin
      wb(0, i[7:0], 0);
      if (i < 16 || i == 64)
        chk(r, 0);
    end
    run <= 1;
    n = ($random(seed) & 7) + 1;
    wb(1, 8'h00, 32'h0000_0080);
    wb(1, 8'h04, n);
    wb(0, 8'h08, 0);
    chk(r, n);
    wb(1, 8'h00, 32'h0000_0090);
    wb(1, 8'h04, n + 5);
    wb(0, 8'h08, 0);
    chk(r, n);
    wb(1, 8'h00, 32'h0000_0080);
    wb(1, 8'h04, n);
    wb(1, 8'h14, 1);
    gate <= 0;
    meas;
    chk(c, (n + 1) * 6);
    meas;
    chk(c, (n + 1) * 6);
    chk(irq, 1);
    gate <= 1;
    repeat (8) @(posedge clk);
    wb(0, 8'h08, 0);
    m = r;
    repeat (20) @(posedge clk);
    wb(0, 8'h08, 0);
    chk(r, m);
    wb(1, 8'h10, 1);
    wb(0, 8'h0c, 0);
    chk(r, 0);
    chk(irq, 0);
    m = $random(seed) & 3;
    l = ($random(seed) & 3) + 1;
    wb(1, 8'h00, 32'h0000_0084);
    wb(1, 8'h04, m * 256 + l);
    gate <= 0;
    repeat (2)
    begin
      meas;
      chk(c, v ? l * 6 : ((m + 1) * (l + 1) - l) * 6);
    end
    wb(1, 8'h04, m * 256);
    meas;
    chk(c, (m + 1) * 6);
    wb(1, 8'h04, 0);
    meas;
    chk(c, 6);
    wb(1, 8'h04, n);
    trst_n <= 0;
    repeat (40) @(posedge clk);
    chk(out, 0);
    wb(0, 8'h08, 0);
    chk(r, n);
    trst_n <= 1;
    wb(1, 8'h00, 32'h0000_0081);
    repeat (40) @(posedge clk);
    wb(0, 8'h08, 0);
    chk(r, n);
    wb(1, 8'h14, 0);
    wb(1, 8'h00, 0);
    chk(out, 0);
    print_verdict;
  end
endmodule
